// ### core/prox_calib_defs.svh
// Register offsets, field positions and reset values of the proximity
// calibration and interrupt register bank.
// Assumes a Wishbone slave with 32-bit data; each register index sits at
// byte address four times the index, data in the low byte.
//
// Contract
// - Goal code in bits 7:5, reset 2; codes pick targets 3 to 511.
// - Chosen target is the no-object baseline so results stay above zero.
// - With auto trim enabled, offset is decremented when result falls too low; here not while a calibration runs.
// - Bits 2:0 pick averaging: 0 off, 1 to 7 give 2 to 128 samples.
// - Trim-applied flag sets on every automatic offset decrement.
// - Trim-applied flag clears on write of one or auto trim written zero.
// - Status bit 0 is a read-back copy of the calibration interrupt flag.
// - That copy clears whenever the calibration interrupt flag clears.
// - Six reset-zero interrupt enables in bits 7:2; bits 1:0 reserved.
// - Lot-code byte is factory set, differs per part, read-only.
// - Calibration steps the offset until result is nearest the target; here the search ends on the lowest result still above it.
// - On finish, calibration flag rises and result loads into offset.
// - Offset is an 8-bit magnitude plus sign bit, range plus/minus 255.
// - Interrupt pin drives only when a flag and its enable are both set; here it comes from a flop, one cycle behind them.
`ifndef PROX_CALIB_DEFS_SVH
`define PROX_CALIB_DEFS_SVH

// Register indices.
`define TRIM_MAG_IDX 8'hC0
`define TRIM_SIGN_IDX 8'hC1
`define CALIB_CTRL_IDX 8'hD7
`define CALIB_CONFIG_IDX 8'hD9
`define IRQ_STATUS_IDX 8'hDB
`define CALIB_STATUS_IDX 8'hDC
`define IRQ_ENABLE_IDX 8'hDD
`define LOT_CODE_IDX 8'hE6

// Field positions.
`define GOAL_MSB 7
`define GOAL_LSB 5
`define AUTO_TRIM_BIT 3
`define AVG_MSB 2
`define AVG_LSB 0
`define TRIM_FLAG_BIT 2
`define DONE_COPY_BIT 0
`define START_BIT 0
`define IRQ_LIGHT_SAT 7
`define IRQ_NEAR_SAT 6
`define IRQ_NEAR_THR 5
`define IRQ_LIGHT_THR 4
`define IRQ_CALIB 3
`define IRQ_ZERO 2

// Reset values and offset magnitude limit.
`define CALIB_CONFIG_RST 8'h50
`define IRQ_BITS_RST 6'h00
`define TRIM_MAG_MAX 8'hFF

`endif

// ### core/prox_calib_pkg.sv
// Types shared by the calibration register bank and its offset search.
// Assumes nothing beyond the single system clock.
package prox_calib_pkg;
    typedef enum logic [1:0] {CAL_IDLE, CAL_APPLY, CAL_WAIT} cal_state_t;
    typedef logic [7:0] reg_byte_t;
endpackage : prox_calib_pkg

// ### core/prox_offset_search.sv
// Successive approximation search of the proximity offset.
// Assumes the proximity engine returns one result pulse per applied trial.
`timescale 1ns/10ps
`include "prox_calib_defs.svh"
module prox_offset_search #(
    parameter int RESULT_W = 10
) (
    input wire logic i_clk, // System clock.
    input wire logic i_reset, // Asynchronous reset, active high.
    input wire logic i_start, // One-cycle start request.
    input wire logic [RESULT_W-1:0] i_goal, // Target result value.
    input wire logic [RESULT_W-1:0] i_result, // Proximity result.
    input wire logic i_result_valid, // Result strobe.
    output logic o_busy, // Search in progress.
    output logic o_load, // Load pulse for the trim registers.
    output prox_calib_pkg::reg_byte_t o_load_mag, // Magnitude to load.
    output logic o_load_sign, // Sign to load.
    output logic o_done // One-cycle finish pulse.
);
    prox_calib_pkg::cal_state_t state_q;
    logic [8:0] trial_q;
    logic [3:0] bit_q;
    logic [8:0] next_trial;
    logic keep;

    // Offset code u maps to u - 256, code 0 clamping to -255, so code 1 is -255 and 511 is +255.
    function automatic logic [8:0] to_sm(input logic [8:0] u);
        logic [8:0] neg;
        neg = 9'h100 - u;
        if (u[8]) begin
            to_sm = {1'b0, u[7:0]};
        end else if (u == 9'h000) begin
            to_sm = {1'b1, `TRIM_MAG_MAX};
        end else begin
            to_sm = {1'b1, neg[7:0]};
        end
    endfunction : to_sm

    // A result still above the goal needs more offset, so the bit stays.
    always_comb begin
        keep = i_result > i_goal;
        next_trial = trial_q;
        if (!keep) begin
            next_trial[bit_q] = 1'b0;
        end
        if (bit_q != 4'h0) begin
            next_trial[bit_q - 4'h1] = 1'b1;
        end
    end

    // Search sequencer: apply a trial, wait one result, settle one bit.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= prox_calib_pkg::CAL_IDLE;
            trial_q <= 9'h000;
            bit_q <= 4'h0;
            o_load <= 1'b0;
            o_done <= 1'b0;
            o_load_mag <= 8'h00;
            o_load_sign <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_load <= 1'b0;
            o_done <= 1'b0;
            unique case (state_q)
                prox_calib_pkg::CAL_IDLE: begin
                    if (i_start) begin
                        trial_q <= 9'h100;
                        o_busy <= 1'b1;
                        bit_q <= 4'h8;
                        state_q <= prox_calib_pkg::CAL_APPLY;
                    end
                end
                prox_calib_pkg::CAL_APPLY: begin
                    o_load <= 1'b1;
                    {o_load_sign, o_load_mag} <= to_sm(trial_q);
                    state_q <= prox_calib_pkg::CAL_WAIT;
                end
                prox_calib_pkg::CAL_WAIT: begin
                    if (i_result_valid) begin
                        trial_q <= next_trial;
                        if (bit_q == 4'h0) begin
                            o_load <= 1'b1;
                            o_done <= 1'b1;
                            o_busy <= 1'b0;
                            {o_load_sign, o_load_mag} <= to_sm(next_trial);
                            state_q <= prox_calib_pkg::CAL_IDLE;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                            state_q <= prox_calib_pkg::CAL_APPLY;
                        end
                    end
                end
            endcase
        end
    end

    // Every accepted start must put a trial offset out two cycles later.
    a_trial_follows: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_start && !o_busy) |-> ##2 o_load)
        else $error("Calibration start gave no trial offset.");
endmodule : prox_offset_search

// ### core/prox_calib_irq_regs.sv
// Proximity calibration settings, status, interrupt enables and lot code,
// reached as a classic Wishbone slave, plus the offset search it starts.
// Assumes the proximity engine runs on I_CLK_SYS and gives one-cycle event
// pulses; the lot-code pins are static straps from outside the clock.
`timescale 1ns/10ps
`include "prox_calib_defs.svh"
module prox_calib_irq_regs #(
    parameter int RESULT_W = 10
) (
    input wire logic I_CLK_SYS, // 10 MHz system clock.
    input wire logic I_RESET, // Asynchronous reset, active high.
    input wire logic I_CYC, // Wishbone cycle.
    input wire logic I_STB, // Wishbone strobe.
    input wire logic I_WE, // Wishbone write enable.
    input wire logic [9:0] I_ADR, // Wishbone byte address.
    input wire logic [3:0] I_SEL, // Wishbone byte selects.
    input wire logic [31:0] I_DAT, // Wishbone write data.
    output logic [31:0] O_DAT, // Wishbone read data.
    output logic O_ACK, // Wishbone acknowledge.
    input wire logic [RESULT_W-1:0] I_NEAR_RESULT, // Proximity result.
    input wire logic I_NEAR_RESULT_VALID, // Result strobe.
    input wire logic I_NEAR_LOW, // Result fell below its lower limit.
    input wire logic I_LIGHT_SAT_EVT, // Light saturation event.
    input wire logic I_NEAR_SAT_EVT, // Proximity saturation event.
    input wire logic I_NEAR_THRESH_EVT, // Proximity threshold event.
    input wire logic I_LIGHT_THRESH_EVT, // Light threshold event.
    input wire logic I_ZERO_DETECT_EVT, // Zero detect event.
    input wire logic [7:0] I_LOT_CODE, // Factory lot-code straps.
    output logic [RESULT_W-1:0] O_CALIB_GOAL, // Decoded target result.
    output logic [2:0] O_SAMPLE_AVG_CODE, // Averaging selection.
    output logic [7:0] O_NEAR_TRIM_MAGNITUDE, // Offset magnitude.
    output logic O_NEAR_TRIM_SIGN, // Offset sign, high for negative.
    output logic O_CALIB_ACTIVE, // Calibration in progress.
    output logic O_INT // Level interrupt, active high.
);
    prox_calib_pkg::reg_byte_t calib_config_q;
    logic [7:2] irq_stat_q;
    logic [7:2] irq_en_q;
    logic trim_applied_flag_q;
    prox_calib_pkg::reg_byte_t trim_mag_q;
    logic trim_sign_q;
    prox_calib_pkg::reg_byte_t lot_meta_q;
    prox_calib_pkg::reg_byte_t lot_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic int_q;
    logic [RESULT_W-1:0] goal_q;
    logic [2:0] avg_q;
    prox_calib_pkg::reg_byte_t rd_d;
    logic [7:2] evt;
    logic [7:0] idx;
    logic req;
    logic wr;
    logic wr_cfg;
    logic wr_cstat;
    logic wr_istat;
    logic wr_ien;
    logic wr_ctrl;
    logic wr_mag;
    logic wr_sign;
    logic dec_ok;
    logic trim_dec;
    logic cal_start;
    logic cal_busy;
    logic cal_load;
    prox_calib_pkg::reg_byte_t cal_mag;
    logic cal_sign;
    logic cal_done;

    // The goal decode needs room for the largest target of 511.
    if (RESULT_W < 10) begin : g_width_check
        $error("RESULT_W must be at least 10.");
    end

    // Bus decode. The index sits above the two byte-offset bits.
    assign idx = I_ADR[9:2];
    assign req = I_CYC && I_STB && !ack_q;
    assign wr = I_CYC && I_STB && I_WE && ack_q && I_SEL[0];
    assign wr_cfg = wr && (idx == `CALIB_CONFIG_IDX);
    assign wr_cstat = wr && (idx == `CALIB_STATUS_IDX);
    assign wr_istat = wr && (idx == `IRQ_STATUS_IDX);
    assign wr_ien = wr && (idx == `IRQ_ENABLE_IDX);
    assign wr_ctrl = wr && (idx == `CALIB_CTRL_IDX);
    assign wr_mag = wr && (idx == `TRIM_MAG_IDX);
    assign wr_sign = wr && (idx == `TRIM_SIGN_IDX);

    // Acknowledge one cycle after the request; the read word is latched
    // then, and a write commits at the edge where the master sees ack.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= {24'h00_0000, rd_d};
            end
        end
    end

    // Read mux. Unmapped indices read as zero; reserved bits read as zero except config bit 4, which reads as stored.
    always_comb begin
        rd_d = 8'h00;
        unique case (idx)
            `CALIB_CONFIG_IDX: rd_d = calib_config_q;
            `CALIB_STATUS_IDX: begin
                rd_d[`TRIM_FLAG_BIT] = trim_applied_flag_q;
                rd_d[`DONE_COPY_BIT] = irq_stat_q[`IRQ_CALIB];
            end
            `IRQ_STATUS_IDX: rd_d[7:2] = irq_stat_q;
            `IRQ_ENABLE_IDX: rd_d[7:2] = irq_en_q;
            `LOT_CODE_IDX: rd_d = lot_q;
            `CALIB_CTRL_IDX: rd_d[`START_BIT] = cal_busy;
            `TRIM_MAG_IDX: rd_d = trim_mag_q;
            `TRIM_SIGN_IDX: rd_d[0] = trim_sign_q;
            default: rd_d = 8'h00;
        endcase
    end

    // Calibration configuration. All eight bits are stored as written, so
    // the reserved bit keeps whatever software puts there.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            calib_config_q <= `CALIB_CONFIG_RST;
        end else if (wr_cfg) begin
            calib_config_q <= I_DAT[7:0];
        end
    end

    // Goal decode: code n gives 2^(n+2) - 1, so 0 gives 3 and 7 gives 511.
    // The engine gets the target and averaging code from flops.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            goal_q <= '0;
            avg_q <= 3'h0;
        end else begin
            goal_q <= RESULT_W'((11'h004 << calib_config_q[7:5]) - 11'h001);
            avg_q <= calib_config_q[`AVG_MSB:`AVG_LSB];
        end
    end

    // Lot-code straps pass two flops; the byte is never written by software.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            lot_meta_q <= 8'h00;
            lot_q <= 8'h00;
        end else begin
            lot_meta_q <= I_LOT_CODE;
            lot_q <= lot_meta_q;
        end
    end

    // Automatic decrement stands aside while a calibration owns the offset,
    // and stops at -255 rather than wrapping round.
    assign dec_ok = calib_config_q[`AUTO_TRIM_BIT] && I_NEAR_LOW && !cal_busy;
    assign trim_dec = dec_ok && !(trim_sign_q && trim_mag_q == `TRIM_MAG_MAX);

    // Offset registers: calibration load wins over decrement over software.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            trim_mag_q <= 8'h00;
            trim_sign_q <= 1'b0;
        end else if (cal_load) begin
            trim_mag_q <= cal_mag;
            trim_sign_q <= cal_sign;
        end else if (trim_dec) begin
            if (!trim_sign_q && trim_mag_q != 8'h00) begin
                trim_mag_q <= trim_mag_q - 8'h01;
            end else begin
                trim_sign_q <= 1'b1;
                trim_mag_q <= trim_mag_q + 8'h01;
            end
        end else begin
            if (wr_mag) begin
                trim_mag_q <= I_DAT[7:0];
            end
            if (wr_sign) begin
                trim_sign_q <= I_DAT[0];
            end
        end
    end

    // Trim-applied flag: a decrement in the clearing cycle wins.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            trim_applied_flag_q <= 1'b0;
        end else if (trim_dec) begin
            trim_applied_flag_q <= 1'b1;
        end else if ((wr_cstat && I_DAT[`TRIM_FLAG_BIT]) ||
                     (wr_cfg && !I_DAT[`AUTO_TRIM_BIT])) begin
            trim_applied_flag_q <= 1'b0;
        end
    end

    // Interrupt enables. Bits 1:0 are not stored and read as zero.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            irq_en_q <= `IRQ_BITS_RST;
        end else if (wr_ien) begin
            irq_en_q <= I_DAT[7:2];
        end
    end

    // Event sources, laid out like the enable register.
    assign evt[`IRQ_LIGHT_SAT] = I_LIGHT_SAT_EVT;
    assign evt[`IRQ_NEAR_SAT] = I_NEAR_SAT_EVT;
    assign evt[`IRQ_NEAR_THR] = I_NEAR_THRESH_EVT;
    assign evt[`IRQ_LIGHT_THR] = I_LIGHT_THRESH_EVT;
    assign evt[`IRQ_CALIB] = cal_done;
    assign evt[`IRQ_ZERO] = I_ZERO_DETECT_EVT;

    // Sticky flags, cleared by writing one; an event in the clearing cycle
    // is kept so that no interrupt is lost.
    for (genvar i = 2; i <= 7; i++) begin : g_irq_flag
        always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
            if (I_RESET) begin
                irq_stat_q[i] <= 1'b0;
            end else if (evt[i]) begin
                irq_stat_q[i] <= 1'b1;
            end else if (wr_istat && I_DAT[i]) begin
                irq_stat_q[i] <= 1'b0;
            end
        end
    end

    // Interrupt level from a flop, one cycle behind its flags.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            int_q <= 1'b0;
        end else begin
            int_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // Writing one to the start bit begins a run; ignored while one runs.
    assign cal_start = wr_ctrl && I_DAT[`START_BIT] && !cal_busy;

    prox_offset_search #(
        .RESULT_W(RESULT_W)
    ) u_search (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_start(cal_start),
        .i_goal(goal_q),
        .i_result(I_NEAR_RESULT),
        .i_result_valid(I_NEAR_RESULT_VALID),
        .o_busy(cal_busy),
        .o_load(cal_load),
        .o_load_mag(cal_mag),
        .o_load_sign(cal_sign),
        .o_done(cal_done)
    );

    // Outputs, each straight from a flop.
    assign O_DAT = dat_q;
    assign O_ACK = ack_q;
    assign O_INT = int_q;
    assign O_CALIB_GOAL = goal_q;
    assign O_SAMPLE_AVG_CODE = avg_q;
    assign O_NEAR_TRIM_MAGNITUDE = trim_mag_q;
    assign O_NEAR_TRIM_SIGN = trim_sign_q;
    assign O_CALIB_ACTIVE = cal_busy;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RESET);

    // Target output tracks the stored goal code one cycle on; the reset
    // edge itself is skipped because the flop is still forced to zero.
    a_goal_decode: assert property (
        !I_RESET |=> O_CALIB_GOAL ==
            RESULT_W'((11'h004 << $past(calib_config_q[7:5])) - 11'h001))
        else $error("Calibration target does not match the goal code.");

    // Averaging output follows the stored field.
    a_avg_follow: assert property (
        ##1 O_SAMPLE_AVG_CODE == $past(calib_config_q[2:0]))
        else $error("Averaging code output is stale.");

    // A positive offset steps down by exactly one on a low result.
    a_trim_step: assert property (
        (dec_ok && !cal_load && !trim_sign_q && trim_mag_q != 8'h00)
            |=> trim_mag_q == $past(trim_mag_q) - 8'h01 && !trim_sign_q)
        else $error("Automatic decrement did not step the offset.");

    // Each decrement raises the trim-applied flag.
    a_flag_set: assert property (
        trim_dec |=> trim_applied_flag_q)
        else $error("Trim-applied flag not set after decrement.");

    // Clearing by write of one, or auto trim off, with no new decrement.
    a_flag_clear: assert property (
        (((wr_cstat && I_DAT[2]) || (wr_cfg && !I_DAT[3])) && !trim_dec)
            |=> !trim_applied_flag_q)
        else $error("Trim-applied flag survived its clear.");

    // A status read returns the calibration flag in bit 0.
    a_done_copy: assert property (
        (req && idx == `CALIB_STATUS_IDX && !I_WE)
            |=> O_ACK && O_DAT[0] == $past(irq_stat_q[`IRQ_CALIB]))
        else $error("Calibration copy differs from its flag.");

    // Interrupt pin equals the masked flags one cycle later.
    a_irq_level: assert property (
        ##1 O_INT == $past(|(irq_stat_q & irq_en_q)))
        else $error("Interrupt level disagrees with flags and enables.");

    // Finish loads the result and raises the calibration flag together.
    a_cal_finish: assert property (
        cal_done |=> irq_stat_q[`IRQ_CALIB] &&
            trim_mag_q == $past(cal_mag) && trim_sign_q == $past(cal_sign))
        else $error("Calibration finish did not load offset and flag.");

    // Writes elsewhere, including the lot code, leave the config alone.
    a_write_isolated: assert property (
        (wr && idx != `CALIB_CONFIG_IDX) |=> $stable(calib_config_q))
        else $error("Foreign write changed the configuration.");

    // Writing zero to a set status bit leaves it set; only ones clear,
    // so software cannot drop an event it has not yet seen.
    a_status_hold: assert property (
        wr_istat |=> &(irq_stat_q | ~$past(irq_stat_q & ~I_DAT[7:2])))
        else $error("Status bit cleared by a write of zero.");

    // A zero or negative offset grows in magnitude with the sign set,
    // staying within the magnitude-plus-sign range.
    a_trim_negstep: assert property (
        (trim_dec && !cal_load && (trim_sign_q || trim_mag_q == 8'h00))
            |=> trim_sign_q && trim_mag_q == $past(trim_mag_q) + 8'h01)
        else $error("Negative offset step went wrong.");

    // A lot-code read returns the synchronised straps.
    a_lot_read: assert property (
        (req && idx == `LOT_CODE_IDX) |=> O_DAT[7:0] == $past(lot_q))
        else $error("Lot-code read differs from the straps.");

    // An enable read returns the six enables with the reserved bits zero.
    a_enable_read: assert property (
        (req && idx == `IRQ_ENABLE_IDX)
            |=> O_DAT[7:0] == {$past(irq_en_q), 2'b00})
        else $error("Enable read-back is wrong.");

    // Main scenarios: calibration, auto trim, interrupt rise and clears.
    c_cal_done: cover property (cal_done);
    c_auto_dec: cover property (trim_dec ##1 trim_applied_flag_q);
    c_irq_up: cover property (!O_INT ##1 O_INT);
    c_flag_clear: cover property (wr_istat && I_DAT[3] && irq_stat_q[3]);
    c_cal_start: cover property (cal_start);
endmodule : prox_calib_irq_regs

// ### bench/prox_engine_model.sv
// Behavioural proximity engine answering the offset search.
// Assumes a positive offset lowers the result and results clip to 10 bits.
`timescale 1ns/10ps
module prox_engine_model #(
    parameter int BASE = 200
) (
    input wire logic i_clk, // System clock.
    input wire logic i_active, // Calibration running.
    input wire logic [7:0] i_mag, // Offset magnitude.
    input wire logic i_sign, // Offset sign, high for negative.
    output logic [9:0] o_result, // Proximity result.
    output logic o_valid // Result strobe.
);
    int cnt = 0;
    int r;
    logic [9:0] v;
    // One result every five cycles, so each trial has settled when read.
    // Between strobes the bus shows the inverse, never a stale result.
    always @(posedge i_clk) begin
        r = BASE - (i_sign ? -int'(i_mag) : int'(i_mag));
        v = (r < 0) ? 10'h000 : (r > 1023) ? 10'h3ff : r[9:0];
        cnt <= i_active ? (cnt + 1) % 5 : 0;
        o_valid <= i_active && cnt == 4;
        o_result <= (i_active && cnt == 4) ? v : ~v;
    end
endmodule : prox_engine_model

// ### bench/tb_prox_calib_irq_regs.sv
// Self-checking bench for the calibration register bank.
// Assumes the design's one-cycle Wishbone answer and 10-bit results.
`timescale 1ns/10ps
`include "prox_calib_defs.svh"
module tb_prox_calib_irq_regs;
    logic I_CLK_SYS, I_RESET, I_CYC, I_STB, I_WE, I_NEAR_LOW, O_ACK, O_INT;
    logic [9:0] I_ADR, I_NEAR_RESULT, O_CALIB_GOAL;
    logic [3:0] I_SEL;
    logic [31:0] I_DAT, O_DAT;
    logic [7:0] ev, O_NEAR_TRIM_MAGNITUDE, rd;
    logic [2:0] O_SAMPLE_AVG_CODE;
    logic O_NEAR_TRIM_SIGN, O_CALIB_ACTIVE, I_NEAR_RESULT_VALID;
    int fails = 0;
    int checked = 0;
    prox_calib_irq_regs dut (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
        .I_CYC(I_CYC), .I_STB(I_STB), .I_WE(I_WE), .I_ADR(I_ADR),
        .I_SEL(I_SEL), .I_DAT(I_DAT), .O_DAT(O_DAT), .O_ACK(O_ACK),
        .I_NEAR_RESULT(I_NEAR_RESULT),
        .I_NEAR_RESULT_VALID(I_NEAR_RESULT_VALID), .I_NEAR_LOW(I_NEAR_LOW),
        .I_LIGHT_SAT_EVT(ev[7]), .I_NEAR_SAT_EVT(ev[6]),
        .I_NEAR_THRESH_EVT(ev[5]), .I_LIGHT_THRESH_EVT(ev[4]),
        .I_ZERO_DETECT_EVT(ev[2]), .I_LOT_CODE(8'ha5),
        .O_CALIB_GOAL(O_CALIB_GOAL), .O_SAMPLE_AVG_CODE(O_SAMPLE_AVG_CODE),
        .O_NEAR_TRIM_MAGNITUDE(O_NEAR_TRIM_MAGNITUDE),
        .O_NEAR_TRIM_SIGN(O_NEAR_TRIM_SIGN), .O_CALIB_ACTIVE(O_CALIB_ACTIVE),
        .O_INT(O_INT));
    prox_engine_model #(.BASE(200)) eng (.i_clk(I_CLK_SYS),
        .i_active(O_CALIB_ACTIVE), .i_mag(O_NEAR_TRIM_MAGNITUDE),
        .i_sign(O_NEAR_TRIM_SIGN), .o_result(I_NEAR_RESULT),
        .o_valid(I_NEAR_RESULT_VALID));
    // Free-running 10 MHz clock.
    initial begin
        I_CLK_SYS = 1'b0;
        forever #50 I_CLK_SYS = ~I_CLK_SYS;
    end
    // Prints the counts and the verdict, then ends the run.
    task final_report;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // Compares a result against its expected value.
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle; held until ack is sampled, then released.
    task wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        I_CYC <= 1'b1;
        I_STB <= 1'b1;
        I_WE <= we;
        I_ADR <= {idx, 2'b00};
        I_DAT <= {24'h00_0000, wd};
        n = 0;
        do begin
            @(posedge I_CLK_SYS);
            n++;
        end while (O_ACK !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            final_report();
        end
        rd = O_DAT[7:0];
        I_CYC <= 1'b0;
        I_STB <= 1'b0;
        I_WE <= 1'b0;
        @(posedge I_CLK_SYS);
    endtask : wb
    task rchk(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk({8'h00, rd}, {8'h00, exp});
    endtask : rchk
    task tick(input int n);
        repeat (n) @(posedge I_CLK_SYS);
    endtask : tick
    task t_reset_values;
        chk({6'h00, O_CALIB_GOAL}, 16'h000f);
        chk({13'h0000, O_SAMPLE_AVG_CODE}, 16'h0000);
        rchk(`CALIB_CONFIG_IDX, 8'h50);
        rchk(`IRQ_ENABLE_IDX, 8'h00);
        rchk(`CALIB_STATUS_IDX, 8'h00);
        rchk(`LOT_CODE_IDX, 8'ha5);
    endtask : t_reset_values
    task t_goal_avg;
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, `CALIB_CONFIG_IDX, {c[2:0], 2'b10, c[2:0]});
            rchk(`CALIB_CONFIG_IDX, {c[2:0], 2'b10, c[2:0]});
            chk({6'h00, O_CALIB_GOAL}, 16'h0004 * (2 ** c) - 1);
            chk({13'h0000, O_SAMPLE_AVG_CODE}, {13'h0000, c[2:0]});
        end
    endtask : t_goal_avg
    task t_read_only;
        wb(1'b1, `LOT_CODE_IDX, 8'h3c);
        rchk(`LOT_CODE_IDX, 8'ha5);
        wb(1'b1, 8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        wb(1'b1, `IRQ_ENABLE_IDX, 8'hff);
        rchk(`IRQ_ENABLE_IDX, 8'hfc);
        wb(1'b1, `IRQ_ENABLE_IDX, 8'h00);
    endtask : t_read_only
    task low_pulse;
        I_NEAR_LOW <= 1'b1;
        tick(1);
        I_NEAR_LOW <= 1'b0;
        tick(3);
    endtask : low_pulse
    task t_auto_trim;
        wb(1'b1, `TRIM_MAG_IDX, 8'h01);
        low_pulse();
        chk({8'h00, O_NEAR_TRIM_MAGNITUDE}, 16'h0001);
        wb(1'b1, `CALIB_CONFIG_IDX, 8'h58);
        low_pulse();
        chk({7'h00, O_NEAR_TRIM_SIGN, O_NEAR_TRIM_MAGNITUDE}, 16'h0000);
        rchk(`CALIB_STATUS_IDX, 8'h04);
        wb(1'b1, `CALIB_STATUS_IDX, 8'h00);
        rchk(`CALIB_STATUS_IDX, 8'h04);
        wb(1'b1, `CALIB_STATUS_IDX, 8'h04);
        rchk(`CALIB_STATUS_IDX, 8'h00);
        low_pulse();
        chk({7'h00, O_NEAR_TRIM_SIGN, O_NEAR_TRIM_MAGNITUDE}, 16'h0101);
        wb(1'b1, `CALIB_CONFIG_IDX, 8'h50);
        rchk(`CALIB_STATUS_IDX, 8'h00);
    endtask : t_auto_trim
    task t_calibrate;
        int u;
        int off;
        u = 0;
        for (int b = 8; b >= 0; b--) begin
            off = (u | (1 << b)) - 256;
            if (200 - off > 15) u = u | (1 << b);
        end
        off = u - 256;
        wb(1'b1, `IRQ_ENABLE_IDX, 8'h08);
        wb(1'b1, `CALIB_CTRL_IDX, 8'h01);
        chk({15'h0000, O_CALIB_ACTIVE}, 16'h0001);
        for (int n = 0; O_CALIB_ACTIVE === 1'b1; n++) begin
            if (n > 200) begin
                fails++;
                final_report();
            end
            tick(1);
        end
        tick(2);
        chk({7'h00, O_NEAR_TRIM_SIGN, O_NEAR_TRIM_MAGNITUDE},
            (off < 0) ? 16'h0100 + 16'(-off) : 16'(off));
        chk({15'h0000, O_INT}, 16'h0001);
        rchk(`CALIB_STATUS_IDX, 8'h01);
        wb(1'b1, `IRQ_STATUS_IDX, 8'h08);
        rchk(`CALIB_STATUS_IDX, 8'h00);
        chk({15'h0000, O_INT}, 16'h0000);
    endtask : t_calibrate
    task t_events;
        for (int b = 2; b < 8; b++) begin
            if (b == 3) continue;
            ev <= 8'h01 << b;
            tick(1);
            ev <= 8'h00;
            tick(3);
            chk({15'h0000, O_INT}, 16'h0000);
            wb(1'b1, `IRQ_ENABLE_IDX, 8'h01 << b);
            tick(2);
            chk({15'h0000, O_INT}, 16'h0001);
            wb(1'b1, `IRQ_STATUS_IDX, 8'h01 << b);
            tick(2);
            chk({15'h0000, O_INT}, 16'h0000);
            wb(1'b1, `IRQ_ENABLE_IDX, 8'h00);
        end
    endtask : t_events
    // Main sequence: reset held for 20 cycles, then each scenario in turn.
    initial begin
        I_RESET = 1'b1;
        {I_CYC, I_STB, I_WE, I_NEAR_LOW} = 4'h0;
        I_ADR = 10'h000;
        I_SEL = 4'h1;
        I_DAT = 32'h0000_0000;
        ev = 8'h00;
        tick(20);
        I_RESET <= 1'b0;
        tick(3);
        t_reset_values();
        t_goal_avg();
        t_read_only();
        t_auto_trim();
        t_calibrate();
        t_events();
        final_report();
    end
endmodule : tb_prox_calib_irq_regs
